// >>> design/adsp_decoder.sv
// Purpose: per-master address decoder plus 80 Kbyte sram block partition
// Assumes: ahb address phase inputs synchronous to ref_clk_in
// Notes: one decoder instance per master, parameterised for processor view
`timescale 1ns/10ps

// ****************************************************************
// one master's decoder
// ****************************************************************
module adsp_master_dec #(
	parameter bit CPU_VIEW = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hready_in,
	input wire logic remap_in,
	input wire logic boot_rom_in,
	input wire logic [1:0] icr_size_in,
	input wire logic [1:0] dcr_size_in,
	output adsp_pkg::adsp_target_t target_out,
	output logic [3:0] ext_sel_out,
	output logic [2:0] ram_block_out,
	output logic [13:0] ram_offset_out,
	output logic hready_out,
	output logic [1:0] hresp_out
);
	logic [3:0] bank;
	logic [7:0] area;
	logic [1:0] slot;
	logic [2:0] slot_hi;
	logic [2:0] blk;
	logic active;
	adsp_pkg::adsp_target_t tgt;
	adsp_pkg::adsp_state_t state_q;
	adsp_pkg::adsp_state_t state_d;

	assign bank = haddr_in[31:28];
	assign area = haddr_in[27:20];
	assign slot_hi = haddr_in[16:14];
	assign slot = haddr_in[15:14];
	assign active = htrans_in[1] & hready_in;

	// sram block lookup for the shared area and the remapped boot window
	function automatic logic [2:0] shr_block(input logic [2:0] idx,
			input logic [1:0] isz, input logic [1:0] dsz);
		logic [2:0] free [5];
		logic [2:0] n;
		for (int i = 0; i < 5; i++) begin
			free[i] = adsp_pkg::ADSP_BLK_NONE;
		end
		n = 3'h1;
		free[0] = adsp_pkg::ADSP_BLK_4;
		if (dsz == 2'h0) begin
			free[n] = 3'h3;
			n = n + 3'h1;
		end
		if (dsz != adsp_pkg::ADSP_SIZE_MAX) begin
			free[n] = 3'h2;
			n = n + 3'h1;
		end
		if (isz == 2'h0) begin
			free[n] = 3'h1;
			n = n + 3'h1;
		end
		if (isz != adsp_pkg::ADSP_SIZE_MAX) begin
			free[n] = 3'h0;
			n = n + 3'h1;
		end
		shr_block = (idx < 3'h5) ? free[idx] : adsp_pkg::ADSP_BLK_NONE;
	endfunction

	// ****************************************************************
	// address phase decode
	// ****************************************************************
	always_comb begin
		tgt = adsp_pkg::ADSP_T_ABORT;
		ext_sel_out = 4'h0;
		blk = adsp_pkg::ADSP_BLK_NONE;
		if (bank >= adsp_pkg::ADSP_BANK_EXT_LO &&
				bank <= adsp_pkg::ADSP_BANK_EXT_HI) begin
			ext_sel_out = bank - adsp_pkg::ADSP_BANK_EXT_LO;
			tgt = (bank >= adsp_pkg::ADSP_BANK_EXT_B) ?
				adsp_pkg::ADSP_T_EXT_B : adsp_pkg::ADSP_T_EXT_A;
		end else if (bank == adsp_pkg::ADSP_BANK_PERIPH) begin
			tgt = adsp_pkg::ADSP_T_BRIDGE;
		end else if (bank == adsp_pkg::ADSP_BANK_INT) begin
			case (area)
				adsp_pkg::ADSP_AREA_BOOT: begin
					if (CPU_VIEW) begin
						if (remap_in) begin
							blk = shr_block(slot_hi, icr_size_in, dcr_size_in);
							if (blk != adsp_pkg::ADSP_BLK_NONE &&
									haddr_in[19:17] == 3'h0) begin
								tgt = adsp_pkg::ADSP_T_SRAM80;
							end
						end else if (boot_rom_in) begin
							tgt = adsp_pkg::ADSP_T_ROM;
						end else begin
							tgt = adsp_pkg::ADSP_T_EXT_A;
						end
					end
				end
				adsp_pkg::ADSP_AREA_ICR: begin
					if (haddr_in[19:16] == 4'h0 &&
							{1'b0, slot} < icr_size_in) begin
						blk = slot[0] ? 3'h0 : 3'h1;
						tgt = adsp_pkg::ADSP_T_SRAM80;
					end
				end
				adsp_pkg::ADSP_AREA_DCR: begin
					if (haddr_in[19:16] == 4'h0 &&
							{1'b0, slot} < dcr_size_in) begin
						blk = slot[0] ? 3'h2 : 3'h3;
						tgt = adsp_pkg::ADSP_T_SRAM80;
					end
				end
				adsp_pkg::ADSP_AREA_SHR: begin
					blk = shr_block(slot_hi, icr_size_in, dcr_size_in);
					if (blk != adsp_pkg::ADSP_BLK_NONE &&
							haddr_in[19:17] == 3'h0) begin
						tgt = adsp_pkg::ADSP_T_SRAM80;
					end
				end
				adsp_pkg::ADSP_AREA_ROM: begin
					if (haddr_in[19:17] == 3'h0) begin
						tgt = adsp_pkg::ADSP_T_ROM;
					end
				end
				adsp_pkg::ADSP_AREA_SRAM16: begin
					if (haddr_in[19:14] == 6'h00) begin
						tgt = adsp_pkg::ADSP_T_SRAM16;
					end
				end
				default: begin
					tgt = adsp_pkg::ADSP_T_ABORT;
				end
			endcase
		end
		if (tgt != adsp_pkg::ADSP_T_SRAM80) begin
			blk = adsp_pkg::ADSP_BLK_NONE;
		end
	end

	assign target_out = active ? tgt : adsp_pkg::ADSP_T_NONE;
	assign ram_block_out = active ? blk : adsp_pkg::ADSP_BLK_NONE;
	assign ram_offset_out = haddr_in[13:0];

	// ****************************************************************
	// two-cycle error response
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			adsp_pkg::ADSP_S_IDLE: begin
				if (active && tgt == adsp_pkg::ADSP_T_ABORT) begin
					state_d = adsp_pkg::ADSP_S_ERR1;
				end
			end
			adsp_pkg::ADSP_S_ERR1: state_d = adsp_pkg::ADSP_S_ERR2;
			adsp_pkg::ADSP_S_ERR2: state_d = adsp_pkg::ADSP_S_IDLE;
			default: state_d = adsp_pkg::ADSP_S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_q <= adsp_pkg::ADSP_S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ahb error: hready low then high, hresp error on both
	assign hready_out = (state_q != adsp_pkg::ADSP_S_ERR1);
	assign hresp_out = (state_q == adsp_pkg::ADSP_S_IDLE) ? 2'h0 : 2'h1;

	a_err_two_cycle: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(state_q == adsp_pkg::ADSP_S_IDLE && active &&
			tgt == adsp_pkg::ADSP_T_ABORT) |=>
		(!hready_out && hresp_out == 2'h1) ##1
		(hready_out && hresp_out == 2'h1))
		else $error("abort not a two-cycle error");
	a_periph_bank_route: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && bank == 4'hf) |-> target_out == adsp_pkg::ADSP_T_BRIDGE)
		else $error("bank 15 not routed to bridge");
	a_ext_bank_route: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && bank == 4'h3) |->
		(target_out == adsp_pkg::ADSP_T_EXT_A && ext_sel_out == 4'h2))
		else $error("bank 3 not chip select 2");
	a_shr_base_blk: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && haddr_in[31:14] == 18'h000c0) |-> ram_block_out == 3'h4)
		else $error("shared base not block 4");
	a_zero_map_sel: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(CPU_VIEW && active && !remap_in && haddr_in[31:20] == 12'h000) |->
		target_out == (boot_rom_in ? adsp_pkg::ADSP_T_ROM :
			adsp_pkg::ADSP_T_EXT_A))
		else $error("boot window wrong");
	a_sram16_hit: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && haddr_in[31:14] == 18'h00140) |->
		(target_out == adsp_pkg::ADSP_T_SRAM16 && hready_out))
		else $error("16k sram miss");
	a_icr_block_one: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && icr_size_in != 2'h0 && haddr_in[31:14] == 18'h00040) |->
		ram_block_out == 3'h1)
		else $error("icr base not block 1");
	a_unused_abort: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in)
		(active && haddr_in[31:20] == 12'h00f) |->
		target_out == adsp_pkg::ADSP_T_ABORT)
		else $error("unused area not aborted");
endmodule

// ****************************************************************
// top: partition control plus one decoder per master
// ****************************************************************
module adsp_decoder (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic boot_select_pin_in,
	input wire logic remap_set_in,
	input wire logic remap_clear_in,
	input wire logic [1:0] icr_size_in,
	input wire logic [1:0] dcr_size_in,
	input wire logic [287:0] haddr_in,
	input wire logic [17:0] htrans_in,
	input wire logic [8:0] hready_in,
	output adsp_pkg::adsp_target_t [8:0] target_out,
	output logic [35:0] ext_sel_out,
	output logic [26:0] ram_block_out,
	output logic [125:0] ram_offset_out,
	output logic [8:0] hready_out,
	output logic [17:0] hresp_out,
	output logic remap_out,
	output logic boot_rom_out,
	output logic [1:0] icr_size_out,
	output logic [1:0] dcr_size_out
);
	logic remap_q;
	logic boot_q;
	logic [1:0] icr_q;
	logic [1:0] dcr_q;

	// remap only by software, cleared by reset
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			remap_q <= 1'b0;
		end else if (remap_set_in) begin
			remap_q <= 1'b1;
		end else if (remap_clear_in) begin
			remap_q <= 1'b0;
		end
	end

	// boot pin caught during reset
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			boot_q <= boot_select_pin_in;
		end
	end

	// coupled sizes; illegal codes ignored
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			icr_q <= adsp_pkg::ADSP_SIZE_RESET;
			dcr_q <= adsp_pkg::ADSP_SIZE_RESET;
		end else begin
			if (icr_size_in <= adsp_pkg::ADSP_SIZE_MAX) begin
				icr_q <= icr_size_in;
			end
			if (dcr_size_in <= adsp_pkg::ADSP_SIZE_MAX) begin
				dcr_q <= dcr_size_in;
			end
		end
	end

	assign remap_out = remap_q;
	assign boot_rom_out = boot_q;
	assign icr_size_out = icr_q;
	assign dcr_size_out = dcr_q;

	generate
		for (genvar m = 0; m < adsp_pkg::ADSP_MASTERS; m++) begin : g_dec
			adsp_master_dec #(
				.CPU_VIEW(m >= adsp_pkg::ADSP_CPU_D)
			) u_dec (
				.ref_clk_in(ref_clk_in),
				.rst_n_in(rst_n_in),
				.haddr_in(haddr_in[m*32 +: 32]),
				.htrans_in(htrans_in[m*2 +: 2]),
				.hready_in(hready_in[m]),
				.remap_in(remap_q),
				.boot_rom_in(boot_q),
				.icr_size_in(icr_q),
				.dcr_size_in(dcr_q),
				.target_out(target_out[m]),
				.ext_sel_out(ext_sel_out[m*4 +: 4]),
				.ram_block_out(ram_block_out[m*3 +: 3]),
				.ram_offset_out(ram_offset_out[m*14 +: 14]),
				.hready_out(hready_out[m]),
				.hresp_out(hresp_out[m*2 +: 2])
			);
		end
	endgenerate

	a_remap_reset_clr: assert property (@(posedge ref_clk_in)
		!rst_n_in |=> !remap_out)
		else $error("remap not cleared by reset");
endmodule

// >>> design/adsp_pkg.sv
// Purpose: constants for the per-master address decoder and sram partition
// Assumes: 32-bit AHB-style addresses, one master clock
// Notes: all offsets and bases live here
package adsp_pkg;
	localparam int ADSP_MASTERS = 9;
	localparam logic [3:0] ADSP_BANK_INT = 4'h0;
	localparam logic [3:0] ADSP_BANK_EXT_LO = 4'h1;
	localparam logic [3:0] ADSP_BANK_EXT_HI = 4'h9;
	localparam logic [3:0] ADSP_BANK_EXT_B = 4'h7;
	localparam logic [3:0] ADSP_BANK_PERIPH = 4'hf;
	localparam logic [7:0] ADSP_AREA_BOOT = 8'h00;
	localparam logic [7:0] ADSP_AREA_ICR = 8'h01;
	localparam logic [7:0] ADSP_AREA_DCR = 8'h02;
	localparam logic [7:0] ADSP_AREA_SHR = 8'h03;
	localparam logic [7:0] ADSP_AREA_ROM = 8'h04;
	localparam logic [7:0] ADSP_AREA_SRAM16 = 8'h05;
	localparam logic [3:0] ADSP_SLOT_MAX = 4'h4;
	localparam logic [1:0] ADSP_SIZE_RESET = 2'h0;
	localparam logic [1:0] ADSP_SIZE_MAX = 2'h2;
	localparam logic [2:0] ADSP_BLK_NONE = 3'h7;
	localparam logic [2:0] ADSP_BLK_4 = 3'h4;
	localparam int ADSP_CPU_I = 8;
	localparam int ADSP_CPU_D = 7;
	typedef enum logic [3:0] {
		ADSP_T_NONE = 4'h0,
		ADSP_T_ROM = 4'h1,
		ADSP_T_SRAM80 = 4'h2,
		ADSP_T_SRAM16 = 4'h3,
		ADSP_T_EXT_A = 4'h4,
		ADSP_T_EXT_B = 4'h5,
		ADSP_T_BRIDGE = 4'h6,
		ADSP_T_ABORT = 4'h7
	} adsp_target_t;
	typedef enum logic [1:0] {
		ADSP_S_IDLE = 2'b00,
		ADSP_S_ERR1 = 2'b01,
		ADSP_S_ERR2 = 2'b11
	} adsp_state_t;
endpackage

// >>> tb/adsp_master_model.sv
// Purpose: behavioural bus master driving one decoder port
// Assumes: bench sets address and request on the falling edge
// Notes: request held until the bench drops it
`timescale 1ns/10ps

// ****************
// master port
// ****************
module adsp_master_model (
	input wire logic [31:0] addr_in,
	input wire logic go_in,
	output logic [31:0] haddr_out,
	output logic [1:0] htrans_out
);
	// address stays on the bus, nonseq only while requesting
	assign haddr_out = addr_in;
	assign htrans_out = go_in ? 2'h2 : 2'h0;
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the decoder and sram partition
// Assumes: inputs change on the falling edge
// Notes: decode outputs are combinational, checked 1 ns after a change
`timescale 1ns/10ps

// ****************
// bench
// ****************
module tb_top;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic boot_pin = 1'b1;
	logic rm_set = 1'b0;
	logic rm_clr = 1'b0;
	logic [1:0] isz = 2'h0;
	logic [1:0] dsz = 2'h0;
	logic [287:0] addr = '0;
	logic [8:0] go = '0;
	logic [287:0] haddr;
	logic [17:0] htrans;
	adsp_pkg::adsp_target_t [8:0] tgt;
	logic [35:0] esel;
	logic [26:0] blk;
	logic [125:0] roff;
	logic [8:0] hrdy_in = 9'h1ff;
	logic [8:0] hrdy;
	logic [17:0] hresp;
	logic remap;
	logic brom;
	logic [1:0] isz_q;
	logic [1:0] dsz_q;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	for (genvar m = 0; m < 9; m++) begin : g_m
		adsp_master_model MST(.addr_in(addr[m*32+:32]), .go_in(go[m]),
			.haddr_out(haddr[m*32+:32]), .htrans_out(htrans[m*2+:2]));
	end
	adsp_decoder DUT(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.boot_select_pin_in(boot_pin), .remap_set_in(rm_set),
		.remap_clear_in(rm_clr), .icr_size_in(isz), .dcr_size_in(dsz),
		.haddr_in(haddr), .htrans_in(htrans), .hready_in(hrdy_in),
		.target_out(tgt), .ext_sel_out(esel), .ram_block_out(blk),
		.ram_offset_out(roff), .hready_out(hrdy), .hresp_out(hresp),
		.remap_out(remap), .boot_rom_out(brom), .icr_size_out(isz_q),
		.dcr_size_out(dsz_q));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic dec(input int m, input logic [31:0] a,
		input logic [3:0] t, input logic [2:0] b);
		@(negedge ref_clk_in);
		// no new request while this master's error response runs
		while (hresp[m*2+:2] != 2'h0) begin
			@(negedge ref_clk_in);
		end
		addr[m*32+:32] = a;
		go[m] = 1'b1;
		#1;
		cmp(tgt[m], t);
		if (t == adsp_pkg::ADSP_T_SRAM80) begin
			cmp(blk[m*3+:3], b);
			cmp(roff[m*14+:14], a[13:0]);
		end
		@(negedge ref_clk_in);
		go[m] = 1'b0;
	endtask
	task automatic part(input logic [1:0] i, input logic [1:0] d);
		@(negedge ref_clk_in);
		isz = i;
		dsz = d;
		@(negedge ref_clk_in);
		cmp({isz_q, dsz_q}, {i, d});
	endtask
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		repeat (5) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		@(negedge ref_clk_in);
		cmp(remap, 0);
		cmp({isz_q, dsz_q}, 0);
		cmp(brom, 1);
		for (int b = 1; b < 10; b++) begin
			dec(0, {b[3:0], 28'h0}, b < 7 ? 4'h4 : 4'h5, 0);
			cmp(esel[3:0], b - 1);
		end
		for (int b = 10; b < 15; b++) begin
			dec(1, {b[3:0], 28'h0123450}, adsp_pkg::ADSP_T_ABORT, 0);
		end
		dec(3, 32'hf000_0000, adsp_pkg::ADSP_T_BRIDGE, 0);
		dec(6, 32'h00a0_0000, adsp_pkg::ADSP_T_ABORT, 0);
		dec(6, 32'h00f0_0000, adsp_pkg::ADSP_T_ABORT, 0);
		dec(5, 32'h0050_0000, adsp_pkg::ADSP_T_SRAM16, 0);
		for (int k = 0; k < 5; k++) begin
			dec(k, 32'h0030_0000 + k * 32'h4000, 4'h2, 4 - k);
		end
		dec(8, 32'h0, adsp_pkg::ADSP_T_ROM, 0);
		dec(7, 32'h000f_fffc, adsp_pkg::ADSP_T_ROM, 0);
		dec(0, 32'h0, adsp_pkg::ADSP_T_ABORT, 0);
		@(negedge ref_clk_in);
		rm_set = 1'b1;
		@(negedge ref_clk_in);
		rm_set = 1'b0;
		cmp(remap, 1);
		dec(8, 32'h0, adsp_pkg::ADSP_T_SRAM80, 4);
		dec(7, 32'h0000_4000, adsp_pkg::ADSP_T_SRAM80, 3);
		dec(2, 32'h0030_0000, adsp_pkg::ADSP_T_SRAM80, 4);
		part(2, 2);
		dec(0, 32'h0010_0000, 4'h2, 1);
		dec(0, 32'h0010_4000, 4'h2, 0);
		dec(1, 32'h0020_0000, 4'h2, 3);
		dec(1, 32'h0020_4000, 4'h2, 2);
		dec(2, 32'h0030_0000, 4'h2, 4);
		part(1, 2);
		dec(2, 32'h0030_4000, 4'h2, 0);
		part(2, 1);
		dec(2, 32'h0030_4000, 4'h2, 2);
		part(1, 1);
		dec(2, 32'h0030_8000, 4'h2, 0);
		part(0, 0);
		dec(2, 32'h0030_4000, 4'h2, 3);
		dec(1, 32'h0030_0000, 4'h2, 4);
		cmp({hrdy[1], hresp[3:2]}, 4);
		hrdy_in[2] = 1'b0;
		dec(2, 32'ha000_0000, adsp_pkg::ADSP_T_NONE, 0);
		hrdy_in[2] = 1'b1;
		cmp(hresp[5:4], 0);
		dec(0, 32'ha000_0000, adsp_pkg::ADSP_T_ABORT, 0);
		cmp({hrdy[0], hresp[1:0]}, 1);
		@(negedge ref_clk_in);
		cmp({hrdy[0], hresp[1:0]}, 5);
		@(negedge ref_clk_in);
		cmp({hrdy[0], hresp[1:0]}, 4);
		rm_clr = 1'b1;
		@(negedge ref_clk_in);
		rm_clr = 1'b0;
		cmp(remap, 0);
		rm_set = 1'b1;
		@(negedge ref_clk_in);
		rm_set = 1'b0;
		boot_pin = 1'b0;
		rst_n_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		cmp(remap, 0);
		dec(8, 32'h0, adsp_pkg::ADSP_T_EXT_A, 0);
		cmp(esel[35:32], 0);
		wrap_up();
	end
endmodule
